// ==== rtl/aadc_pkg.sv ====
// Purpose: Shared types and constants for the converter alarm and serial port block
// Assumes: 16-bit results, 32-bit serial words
// Notes:   Range codes and output word layout are local choices
package aadc_pkg;

  localparam int RESULT_W    = 16;
  localparam int WORD_W      = 32;
  localparam int COUNT_W     = 8;
  localparam int SYNC_STAGES = 2;

  // Pin function setting that routes the alarm onto the shared pin
  localparam logic [1:0] PIN_FN_ALARM = 2'h1;

  // Output word control bit positions
  localparam int OWC_APPEND_INPUT  = 0;
  localparam int OWC_APPEND_SUPPLY = 1;

  // Output word field positions
  localparam int OW_RESULT_LSB = 16;
  localparam int OW_FLAGS_LSB  = 12;

  // Reset values
  localparam logic [15:0] HIGH_TH_RESET = 16'hFFFF;
  localparam logic [15:0] LOW_TH_RESET  = 16'h0000;
  localparam logic [7:0]  HYST_RESET    = 8'h00;

  // Nine ranges; bipolar codes 0..4, unipolar 5..8
  typedef enum logic [3:0] {
    AADC_BI_3P0,
    AADC_BI_2P5,
    AADC_BI_1P5,
    AADC_BI_1P25,
    AADC_BI_0P625,
    AADC_UNI_3P0,
    AADC_UNI_2P5,
    AADC_UNI_1P5,
    AADC_UNI_1P25
  } aadc_range_t;

  typedef struct packed {
    logic [15:0] high_th;
    logic [15:0] low_th;
    logic [7:0]  hyst;
    logic        input_alarm_disable;
    logic        supply_alarm_disable;
  } aadc_alarm_cfg_t;

  // Per source: active and tripped, each with high and low halves
  typedef struct packed {
    logic in_hi_active;
    logic in_hi_tripped;
    logic in_lo_active;
    logic in_lo_tripped;
    logic sup_hi_active;
    logic sup_hi_tripped;
    logic sup_lo_active;
    logic sup_lo_tripped;
  } aadc_flags_t;

endpackage

// ==== rtl/aadc_link.sv ====
// Purpose: Serial shift register on the host's clock
// Assumes: Frame open while select is low; capture on rising, launch on falling
// Notes:   Load word must be stable before the frame opens
`timescale 1ns/10ps
module aadc_link #(
  parameter int WORD_W  = 32,
  parameter int COUNT_W = 8
) (
  input  wire logic               serial_clk,
  input  wire logic               convert_start_select,
  input  wire logic               serial_data_input,
  input  wire logic [WORD_W-1:0]  load_word,
  output logic                    primary_serial_out,
  output logic [WORD_W-1:0]       in_word,
  output logic [COUNT_W-1:0]      edge_count
);

  initial begin
    if (WORD_W < 2 || COUNT_W < $clog2(WORD_W + 1)) begin
      $error("aadc_link: bad widths");
    end
  end

  logic [WORD_W-1:0] out_shift;
  logic              first_edge;
  logic              launch_seen;

  // Select high resets counter and clears the captured word
  always_ff @(posedge serial_clk or posedge convert_start_select) begin
    if (convert_start_select) begin
      in_word    <= '0;
      edge_count <= '0;
    end else begin
      in_word <= {in_word[WORD_W-2:0], serial_data_input};
      if (edge_count != {COUNT_W{1'b1}}) begin
        edge_count <= edge_count + COUNT_W'(1);
      end
    end
  end

  always_ff @(negedge serial_clk or posedge convert_start_select) begin
    if (convert_start_select) begin
      launch_seen <= 1'b0;
    end else begin
      launch_seen <= 1'b1;
    end
  end

  assign first_edge = ~launch_seen;

  // Shift register loads at frame start, MSB leads on the pin
  always_ff @(negedge serial_clk or posedge convert_start_select) begin
    if (convert_start_select) begin
      out_shift <= '0;
    end else if (first_edge) begin
      out_shift <= {load_word[WORD_W-2:0], in_word[0]};
    end else begin
      out_shift <= {out_shift[WORD_W-2:0], in_word[0]};
    end
  end

  // Before the first launch the load word's MSB is already driven
  assign primary_serial_out = first_edge ? load_word[WORD_W-1] : out_shift[WORD_W-1];

endmodule

// ==== rtl/aadc_top.sv ====
// Purpose: Alarm unit and daisy-chain serial port of a 16-bit converter
// Assumes: Result and end-of-conversion come from core logic on core_clk
// Notes:   Link side runs on the host's serial clock; words cross by handshake on select
`timescale 1ns/10ps
module aadc_top #(
  parameter int RESULT_W = aadc_pkg::RESULT_W,
  parameter int WORD_W   = aadc_pkg::WORD_W,
  parameter int COUNT_W  = aadc_pkg::COUNT_W
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  serial_clk,
  input  wire logic                  convert_start_select,
  input  wire logic                  serial_data_input,
  output logic                       primary_serial_out,
  output logic                       shared_alarm_out_pin,
  input  wire logic [RESULT_W-1:0]   conv_result,
  input  wire logic                  conv_done,
  input  wire logic                  supply_over,
  input  wire logic                  supply_under,
  input  wire aadc_pkg::aadc_range_t range_select,
  input  wire logic                  alarm_enable,
  input  wire aadc_pkg::aadc_alarm_cfg_t alarm_cfg,
  input  wire logic [1:0]            second_out_pin_function,
  input  wire logic [1:0]            output_word_control,
  input  wire logic                  flag_read,
  output aadc_pkg::aadc_flags_t      alarm_flags,
  output logic [WORD_W-1:0]          command_word,
  output logic                       command_valid,
  output logic                       range_is_bipolar
);

  initial begin
    if (RESULT_W != 16 || WORD_W != 32 || COUNT_W < 6) begin
      $error("aadc_top: unsupported widths");
    end
  end

  // Code step is span / 2^16 for every range; coding is not range dependent
  // range only reports polarity
  assign range_is_bipolar = range_select <= aadc_pkg::AADC_BI_0P625;

  // ---------------- Alarm comparisons ----------------
  logic [16:0] hi_clear_lim;
  logic [16:0] lo_clear_lim;
  logic        hi_set;
  logic        hi_keep;
  logic        lo_set;
  logic        lo_keep;
  logic        in_en;
  logic        sup_en;
  logic        next_in_hi;
  logic        next_in_lo;
  logic        next_sup_hi;
  logic        next_sup_lo;

  // Widened limits avoid wrap when hysteresis passes zero or full scale
  assign hi_clear_lim = {1'b0, alarm_cfg.high_th} - {9'h000, alarm_cfg.hyst} - 17'h00001;
  assign lo_clear_lim = {1'b0, alarm_cfg.low_th} + {9'h000, alarm_cfg.hyst} + 17'h00001;

  assign hi_set  = conv_result > alarm_cfg.high_th;
  assign lo_set  = conv_result < alarm_cfg.low_th;
  // Held until result reaches the hysteresis limit
  // A clear limit below zero can never be reached, so the alarm stays held
  assign hi_keep = hi_clear_lim[16] ? 1'b1 : ({1'b0, conv_result} > hi_clear_lim);
  assign lo_keep = lo_clear_lim[16] ? 1'b1 : ({1'b0, conv_result} < lo_clear_lim);

  assign in_en  = alarm_enable & ~alarm_cfg.input_alarm_disable;
  assign sup_en = alarm_enable & ~alarm_cfg.supply_alarm_disable;

  assign next_in_hi  = in_en & (hi_set | (alarm_flags.in_hi_active & hi_keep));
  assign next_in_lo  = in_en & (lo_set | (alarm_flags.in_lo_active & lo_keep));
  logic sup_over_q1;
  logic sup_over_q2;
  logic sup_under_q1;
  logic sup_under_q2;
  // Comparator outputs are analog-side, so synchronise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sup_over_q1  <= 1'b0;
      sup_over_q2  <= 1'b0;
      sup_under_q1 <= 1'b0;
      sup_under_q2 <= 1'b0;
    end else begin
      sup_over_q1  <= supply_over;
      sup_over_q2  <= sup_over_q1;
      sup_under_q1 <= supply_under;
      sup_under_q2 <= sup_under_q1;
    end
  end
  assign next_sup_hi = sup_en & sup_over_q2;
  assign next_sup_lo = sup_en & sup_under_q2;

  // ---------------- Flags ----------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm_flags <= '0;
    end else begin
      if (conv_done) begin
        // Active flags re-evaluated at conversion end
        alarm_flags.in_hi_active  <= next_in_hi;
        alarm_flags.in_lo_active  <= next_in_lo;
        alarm_flags.sup_hi_active <= next_sup_hi;
        alarm_flags.sup_lo_active <= next_sup_lo;
      end
      // Detection beats a clearing read
      alarm_flags.in_hi_tripped  <= (conv_done & next_in_hi) |
                                    (alarm_flags.in_hi_tripped & ~flag_read);
      alarm_flags.in_lo_tripped  <= (conv_done & next_in_lo) |
                                    (alarm_flags.in_lo_tripped & ~flag_read);
      alarm_flags.sup_hi_tripped <= (conv_done & next_sup_hi) |
                                    (alarm_flags.sup_hi_tripped & ~flag_read);
      alarm_flags.sup_lo_tripped <= (conv_done & next_sup_lo) |
                                    (alarm_flags.sup_lo_tripped & ~flag_read);
    end
  end

  // Pin is OR of active flags, gated by pin function
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shared_alarm_out_pin <= 1'b0;
    end else begin
      shared_alarm_out_pin <= (second_out_pin_function == aadc_pkg::PIN_FN_ALARM) &
                              (alarm_flags.in_hi_active | alarm_flags.in_lo_active |
                               alarm_flags.sup_hi_active | alarm_flags.sup_lo_active);
    end
  end

  // ---------------- Output word ----------------
  logic [3:0]        in_bits;
  logic [3:0]        sup_bits;
  logic [WORD_W-1:0] out_word;
  logic              sel_q1;
  logic              sel_q2;
  logic              sel_q3;

  assign in_bits  = output_word_control[aadc_pkg::OWC_APPEND_INPUT] ?
                    {alarm_flags.in_hi_active, alarm_flags.in_hi_tripped,
                     alarm_flags.in_lo_active, alarm_flags.in_lo_tripped} : 4'h0;
  assign sup_bits = output_word_control[aadc_pkg::OWC_APPEND_SUPPLY] ?
                    {alarm_flags.sup_hi_active, alarm_flags.sup_hi_tripped,
                     alarm_flags.sup_lo_active, alarm_flags.sup_lo_tripped} : 4'h0;

  // Result MSB first, flags appended after it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_word <= '0;
    end else if (sel_q2) begin
      // Word is frozen while the synchronised select sel_q2 is low so the link sees stable data
      out_word <= {conv_result, in_bits, sup_bits, 8'h00};
    end
  end

  // ---------------- Link domain ----------------
  logic [WORD_W-1:0]  link_in_word;
  logic [COUNT_W-1:0] link_count;

  aadc_link #(
    .WORD_W  (WORD_W),
    .COUNT_W (COUNT_W)
  ) u_link (
    .serial_clk           (serial_clk),
    .convert_start_select (convert_start_select),
    .serial_data_input    (serial_data_input),
    .load_word            (out_word),
    .primary_serial_out   (primary_serial_out),
    .in_word              (link_in_word),
    .edge_count           (link_count)
  );

  // ---------------- Frame end decode ----------------
  logic frame_end;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q1 <= 1'b1;
      sel_q2 <= 1'b1;
      sel_q3 <= 1'b1;
    end else begin
      sel_q1 <= convert_start_select;
      sel_q2 <= sel_q1;
      sel_q3 <= sel_q2;
    end
  end

  // Link word and count are quiet after the rising select; read after two flops
  assign frame_end = sel_q2 & ~sel_q3;

  // Link word is cleared by select high, so keep the last capture
  logic [WORD_W-1:0]  hold_word;
  logic [COUNT_W-1:0] hold_count;
  always_ff @(posedge serial_clk) begin
    hold_word  <= {link_in_word[WORD_W-2:0], serial_data_input};
    // Saturates so very long frames still count as full
    hold_count <= (&link_count) ? link_count : link_count + COUNT_W'(1);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      command_word  <= '0;
      command_valid <= 1'b0;
    end else begin
      command_valid <= frame_end & (hold_count >= COUNT_W'(WORD_W));
      if (frame_end & (hold_count >= COUNT_W'(WORD_W))) begin
        command_word <= hold_word;
      end
    end
  end

endmodule

// ==== bench/aadc_top_assertions.sv ====
// Purpose: Port-level checks of the alarm unit and serial port
// Assumes: alarm_enable held high by the bench
// Notes:   Clear limits use 17 bits so wrap below zero is caught
`timescale 1ns/10ps
module aadc_top_assertions #(
  parameter int RESULT_W = 16
) (
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire logic                     convert_start_select,
  input wire logic                     shared_alarm_out_pin,
  input wire logic [RESULT_W-1:0]      conv_result,
  input wire logic                     conv_done,
  input wire aadc_pkg::aadc_range_t    range_select,
  input wire logic                     alarm_enable,
  input wire aadc_pkg::aadc_alarm_cfg_t alarm_cfg,
  input wire logic [1:0]               second_out_pin_function,
  input wire logic                     flag_read,
  input wire aadc_pkg::aadc_flags_t    alarm_flags,
  input wire logic                     command_valid,
  input wire logic                     range_is_bipolar
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic        in_on = conv_done && alarm_enable && !alarm_cfg.input_alarm_disable;
  wire logic [16:0] hi_lim = {1'b0, alarm_cfg.high_th} - alarm_cfg.hyst - 17'h1;
  wire logic [16:0] lo_lim = {1'b0, alarm_cfg.low_th} + alarm_cfg.hyst + 17'h1;
  wire logic [3:0]  trip = {alarm_flags[6], alarm_flags[4], alarm_flags[2], alarm_flags[0]};
  wire logic [3:0]  act = {alarm_flags[7], alarm_flags[5], alarm_flags[3], alarm_flags[1]};
  wire logic        pin_on = (second_out_pin_function == aadc_pkg::PIN_FN_ALARM) && (|act);

  hi_set_a: assert property (in_on && conv_result > alarm_cfg.high_th |=> act[3] && trip[3])
    else $error("high alarm not set");
  hi_clear_a: assert property (in_on && !hi_lim[16] && {1'b0, conv_result} <= hi_lim |=> !act[3])
    else $error("high alarm not cleared");
  lo_set_a: assert property (in_on && conv_result < alarm_cfg.low_th |=> act[2] && trip[2])
    else $error("low alarm not set");
  lo_clear_a: assert property (in_on && {1'b0, conv_result} >= lo_lim |=> !act[2])
    else $error("low alarm not cleared");
  in_off_a: assert property (conv_done && alarm_cfg.input_alarm_disable |=> act[3:2] == 2'h0)
    else $error("disabled input alarm active");
  act_hold_a: assert property (!conv_done |=> $stable(act))
    else $error("active flags moved between conversions");
  trip_keep_a: assert property (!conv_done && !flag_read |=> $stable(trip))
    else $error("tripped flags moved without read");
  trip_clear_a: assert property (flag_read && !conv_done |=> trip == 4'h0)
    else $error("tripped flags not cleared by read");
  read_race_a: assert property (flag_read && in_on && conv_result > alarm_cfg.high_th |=> trip[3])
    else $error("read beat new detection");
  pin_high_a: assert property (pin_on [*2] |-> shared_alarm_out_pin)
    else $error("alarm pin low with active flag");
  pin_low_a: assert property ((!pin_on) [*2] |-> !shared_alarm_out_pin)
    else $error("alarm pin high without cause");
  cmd_pulse_a: assert property (command_valid |-> convert_start_select && $past(convert_start_select, 2) ##1 !command_valid)
    else $error("command pulse misplaced");
  range_kind_a: assert property (range_is_bipolar == (range_select < aadc_pkg::AADC_UNI_3P0))
    else $error("range kind wrong");

  cover property (in_on && conv_result > alarm_cfg.high_th);
  cover property (flag_read && conv_done);
  cover property (command_valid);
endmodule

// ==== bench/aadc_host.sv ====
// Purpose: Host controller driving select, serial clock and serial input
// Assumes: 48 ns serial period; clock still outside frames
// Notes:   Released data line toggles so a stale bit is never trusted
`timescale 1ns/10ps
module aadc_host (
  output logic      serial_clk,
  output logic      convert_start_select,
  output logic      serial_data_input,
  input  wire logic primary_serial_out
);
  initial begin
    serial_clk = 1'b0;
    convert_start_select = 1'b1;
    serial_data_input = 1'b0;
  end
  always #24 if (convert_start_select) serial_data_input = ~serial_data_input;
  // Filler bits first so the last 32 edges carry the word
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    convert_start_select = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_input = (i < 32) ? tx[i] : ~serial_data_input;
      #12 serial_clk = 1'b1;
      rx = {rx[30:0], primary_serial_out};
      #24 serial_clk = 1'b0;
      #12;
    end
    convert_start_select = 1'b1;
  endtask
endmodule

// ==== bench/aadc_top_tb.sv ====
// Purpose: Self-checking bench for alarm flags, pin and serial frames
// Assumes: alarm_enable tied high
// Notes:   Expected flags come from a bench model of the thresholds
`timescale 1ns/10ps
module aadc_top_tb;
  logic core_clk, rst, conv_done, supply_over, supply_under, alarm_enable, flag_read;
  logic [15:0] conv_result, res;
  aadc_pkg::aadc_range_t range_select;
  aadc_pkg::aadc_alarm_cfg_t alarm_cfg;
  aadc_pkg::aadc_flags_t alarm_flags, ex;
  logic [1:0] second_out_pin_function, output_word_control;
  logic [31:0] command_word, seed;
  logic serial_clk, convert_start_select, serial_data_input, primary_serial_out;
  logic shared_alarm_out_pin, command_valid, range_is_bipolar, d1, d2;
  int err_count, comparisons, cyc;
  aadc_pkg::aadc_flags_t fq[$];
  logic pq[$];
  logic [31:0] cq[$];
  aadc_top dut (.core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
    .convert_start_select(convert_start_select), .serial_data_input(serial_data_input),
    .primary_serial_out(primary_serial_out), .shared_alarm_out_pin(shared_alarm_out_pin),
    .conv_result(conv_result), .conv_done(conv_done), .supply_over(supply_over),
    .supply_under(supply_under), .range_select(range_select), .alarm_enable(alarm_enable),
    .alarm_cfg(alarm_cfg), .second_out_pin_function(second_out_pin_function),
    .output_word_control(output_word_control), .flag_read(flag_read),
    .alarm_flags(alarm_flags), .command_word(command_word), .command_valid(command_valid),
    .range_is_bipolar(range_is_bipolar));
  aadc_host host (.serial_clk(serial_clk), .convert_start_select(convert_start_select),
    .serial_data_input(serial_data_input), .primary_serial_out(primary_serial_out));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Waits first so supply levels cross the synchroniser
  task automatic conv(input logic [15:0] r, input logic rd);
    logic on, sp;
    logic [16:0] hl, ll;
    repeat (4) @(posedge core_clk);
    on = !alarm_cfg.input_alarm_disable;
    sp = !alarm_cfg.supply_alarm_disable;
    hl = {1'b0, alarm_cfg.high_th} - alarm_cfg.hyst - 17'h1;
    ll = {1'b0, alarm_cfg.low_th} + alarm_cfg.hyst + 17'h1;
    if (rd) ex = ex & 8'hAA;
    if (!on || (!hl[16] && {1'b0, r} <= hl)) ex.in_hi_active = 1'b0;
    else if (r > alarm_cfg.high_th) ex.in_hi_active = 1'b1;
    if (!on || {1'b0, r} >= ll) ex.in_lo_active = 1'b0;
    else if (r < alarm_cfg.low_th) ex.in_lo_active = 1'b1;
    ex.sup_hi_active = sp && supply_over;
    ex.sup_lo_active = sp && supply_under;
    ex = ex | {1'b0, ex[7], 1'b0, ex[5], 1'b0, ex[3], 1'b0, ex[1]};
    fq.push_back(ex);
    pq.push_back(second_out_pin_function == aadc_pkg::PIN_FN_ALARM && (ex & 8'hAA) != 8'h0);
    res = r;
    conv_result <= r;
    conv_done <= 1'b1;
    flag_read <= rd;
    @(posedge core_clk);
    conv_done <= 1'b0;
    flag_read <= 1'b0;
    // Pin answer lands before a caller changes the pin function
    repeat (2) @(posedge core_clk);
  endtask
  task automatic frm(input int n, input logic [1:0] oc);
    logic [31:0] tx, rx, ow;
    tx = xs();
    output_word_control <= oc;
    repeat (4) @(posedge core_clk);
    ow = {res, oc[0] ? ex[7:4] : 4'h0, oc[1] ? ex[3:0] : 4'h0, 8'h00};
    if (n >= 32) cq.push_back(tx);
    host.frame(n, tx, rx);
    if (n <= 32) check("out_word", ow >> (32 - n), rx);
    repeat (8) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    d1 <= conv_done;
    d2 <= d1;
    cyc++;
    if (d1) check("flags", {24'h0, fq.pop_front()}, {24'h0, alarm_flags});
    if (d2) check("pin", {31'h0, pq.pop_front()}, {31'h0, shared_alarm_out_pin});
    if (command_valid) check("command", cq.size() ? cq.pop_front() : ~command_word, command_word);
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic [15:0] vals[7];
    vals = '{16'h8001, 16'h7FFC, 16'h7FFB, 16'h0FFF, 16'h1004, 16'h1005, 16'h8001};
    {rst, conv_done, flag_read, supply_over, supply_under, alarm_enable} = 6'h21;
    {d1, d2, conv_result, res, ex, seed} = {2'h0, 32'h0, 8'h0, 32'hDFE4};
    range_select = aadc_pkg::AADC_BI_3P0;
    alarm_cfg = '{16'h8000, 16'h1000, 8'h04, 1'b0, 1'b0};
    second_out_pin_function = aadc_pkg::PIN_FN_ALARM;
    output_word_control = 2'h3;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk) range_select <= aadc_pkg::aadc_range_t'(i);
      @(negedge core_clk) check("bipolar", {31'h0, i < 5}, {31'h0, range_is_bipolar});
    end
    for (int i = 0; i < 7; i++) conv(vals[i], i == 6);
    @(posedge core_clk) flag_read <= 1'b1;
    @(posedge core_clk) flag_read <= 1'b0;
    ex = ex & 8'hAA;
    conv(16'h5000, 1'b0);
    supply_over <= 1'b1;
    conv(16'h5000, 1'b0);
    {supply_over, supply_under} <= 2'h1;
    conv(16'h5000, 1'b0);
    second_out_pin_function <= 2'h0;
    conv(16'h8001, 1'b0);
    second_out_pin_function <= aadc_pkg::PIN_FN_ALARM;
    alarm_cfg <= '{16'h8000, 16'h1000, 8'h04, 1'b1, 1'b1};
    conv(16'h8001, 1'b0);
    alarm_cfg <= '{16'h8000, 16'h1000, 8'h04, 1'b0, 1'b0};
    for (int k = 0; k < 4; k++) begin
      conv(16'(xs()), 1'b0);
      frm((k == 1) ? 20 : (k == 2) ? 40 : 32, 2'(k));
    end
    repeat (10) @(posedge core_clk);
    close_out();
  end
endmodule
bind aadc_top aadc_top_assertions #(.RESULT_W(RESULT_W)) chk (.core_clk(core_clk), .rst(rst),
  .convert_start_select(convert_start_select), .shared_alarm_out_pin(shared_alarm_out_pin),
  .conv_result(conv_result), .conv_done(conv_done), .range_select(range_select),
  .alarm_enable(alarm_enable), .alarm_cfg(alarm_cfg), .flag_read(flag_read),
  .second_out_pin_function(second_out_pin_function), .alarm_flags(alarm_flags),
  .command_valid(command_valid), .range_is_bipolar(range_is_bipolar));
